// *** design/afe_pkg.sv ***
// ----------------------------------------
// register map and field layout
// ----------------------------------------
package afe_pkg;
  localparam logic [4:0] ADDR_CH0 = 5'h00;
  localparam logic [4:0] ADDR_CH1 = 5'h03;
  localparam logic [4:0] ADDR_MOD = 5'h06;
  localparam logic [4:0] ADDR_PH_HI = 5'h07;
  localparam logic [4:0] ADDR_PH_LO = 5'h08;
  localparam logic [4:0] ADDR_GAIN = 5'h09;
  localparam logic [4:0] ADDR_LAST = 5'h1A;
  // group boundaries used by the read address loop
  localparam logic [4:0] GRP_CH0_END = 5'h02;
  localparam logic [4:0] GRP_CH1_END = 5'h05;
  localparam logic [4:0] GRP_CFG_END = 5'h09;
  localparam logic [4:0] GRP_STS_END = 5'h0D;
  localparam logic [4:0] GRP_CAL0_END = 5'h13;
  localparam logic [4:0] GRP_CAL1_END = 5'h19;
  // gain register fields
  localparam int BIAS_LSB = 6;
  localparam int GAIN_CH1_LSB = 3;
  localparam int GAIN_CH0_LSB = 0;
  localparam logic [2:0] GAIN_CODE_MAX = 3'h5;
  // values after reset
  localparam logic [7:0] MOD_RST = 8'h33;
  localparam logic [7:0] GAIN_RST = 8'h80;
  localparam logic [11:0] PHASE_RST = 12'h000;
  localparam logic [23:0] RESULT_RST = 24'h000000;
  // read loop modes
  localparam logic [1:0] LOOP_MAP = 2'h3;
  localparam logic [1:0] LOOP_TYPE = 2'h2;
  localparam logic [1:0] LOOP_GROUP = 2'h1;
  localparam logic [1:0] LOOP_STATIC = 2'h0;
  // gain correction group delay, in master clock periods
  localparam logic [4:0] GCAL_DELAY = 5'h18;
endpackage : afe_pkg

// *** design/afe_regs.sv ***
`timescale 1ns/1ns
// Summary of operation
// - result registers hold the newest finished conversion, readable alone or linked.
// - result registers are read-only; reads return conversion data.
// - a read transaction freezes a consistent snapshot of both results.
// - new results during a read update live registers, not the snapshot.
// - all three result bytes refresh together once per conversion.
// - result field is bits 23..0, bit 23 most significant.
// - with offset or gain correction enabled the corrected code is stored.
// - modulator register tracks latest comparator outputs, one bit each.
// - bits 7..4 second channel, bits 3..0 first channel, comparator 3 high.
// - modulator register resets to the zero-volt pattern.
// - a write to either phase byte pulses a converter reset and restart.
// - phase is 12-bit two's complement, reset zero, upper four bits read zero.
// - bias field 11 x2, 10 x1 reset, 01 x0.66, 00 x0.5.
// - bits 5..3 second channel gain, codes 0..5 give 1..32, 6 and 7 give 1.
// - bits 2..0 first channel gain, same encoding as the second channel.
// - read loop setting steers address auto-increment during continuous reads.
// - gain correction delays result update and data ready by 24 clocks.
module afe_regs (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // serial register access, byte level
  input wire logic txn_active,
  input wire logic cmd_valid,
  input wire logic [4:0] cmd_addr,
  input wire logic byte_rd,
  input wire logic byte_wr,
  input wire logic [7:0] wr_data,
  input wire logic [1:0] read_loop,
  output logic [7:0] rd_data_q,
  output logic [4:0] addr_q,
  // conversion results from the filters
  input wire logic result_valid,
  input wire logic [23:0] ch0_raw,
  input wire logic [23:0] ch1_raw,
  input wire logic [23:0] ch0_corr,
  input wire logic [23:0] ch1_corr,
  input wire logic offset_correction_enable,
  input wire logic gain_correction_enable,
  output logic data_ready_q,
  // modulator comparators
  input wire logic comp_valid,
  input wire logic [7:0] comp_bits,
  // converter control
  output logic conv_restart_q,
  output logic [11:0] phase_q,
  output logic [1:0] bias_sel_q,
  output logic [2:0] ch0_gain_log2_q,
  output logic [2:0] ch1_gain_log2_q
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [23:0] ch0_q;
  logic [23:0] ch1_q;
  logic [23:0] hold0_q;
  logic [23:0] hold1_q;
  logic [23:0] snap0_q;
  logic [23:0] snap1_q;
  logic snap_v_q;
  logic [4:0] dly_q;
  logic [7:0] mod_q;
  logic [7:0] gain_q;
  logic [23:0] sel0;
  logic [23:0] sel1;
  logic [23:0] src0;
  logic [23:0] src1;
  logic upd_direct;
  logic upd_late;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // next byte address for a given loop mode
  function automatic logic [4:0] next_addr(input logic [4:0] a, input logic [1:0] m);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = 5'h00;
    hi = afe_pkg::ADDR_LAST;
    case (m)
      afe_pkg::LOOP_MAP: begin
        lo = 5'h00;
      end
      afe_pkg::LOOP_TYPE: begin
        if (a <= afe_pkg::GRP_CH1_END) begin
          hi = afe_pkg::GRP_CH1_END;
        end else begin
          lo = afe_pkg::ADDR_MOD;
        end
      end
      afe_pkg::LOOP_GROUP: begin
        if (a <= afe_pkg::GRP_CH0_END) begin
          hi = afe_pkg::GRP_CH0_END;
        end else if (a <= afe_pkg::GRP_CH1_END) begin
          lo = afe_pkg::ADDR_CH1;
          hi = afe_pkg::GRP_CH1_END;
        end else if (a <= afe_pkg::GRP_CFG_END) begin
          lo = afe_pkg::ADDR_MOD;
          hi = afe_pkg::GRP_CFG_END;
        end else if (a <= afe_pkg::GRP_STS_END) begin
          lo = afe_pkg::GRP_CFG_END + 5'h01;
          hi = afe_pkg::GRP_STS_END;
        end else if (a <= afe_pkg::GRP_CAL0_END) begin
          lo = afe_pkg::GRP_STS_END + 5'h01;
          hi = afe_pkg::GRP_CAL0_END;
        end else if (a <= afe_pkg::GRP_CAL1_END) begin
          lo = afe_pkg::GRP_CAL0_END + 5'h01;
          hi = afe_pkg::GRP_CAL1_END;
        end else begin
          lo = afe_pkg::ADDR_LAST;
        end
      end
      default: begin
        lo = a;
        hi = a;
      end
    endcase
    next_addr = (a >= hi) ? lo : a + 5'h01;
  endfunction : next_addr

  // reserved gain codes fall back to unity gain
  function automatic logic [2:0] gain_eff(input logic [2:0] c);
    gain_eff = (c > afe_pkg::GAIN_CODE_MAX) ? 3'h0 : c;
  endfunction : gain_eff

  // ----------------------------------------
  // result path
  // ----------------------------------------
  // corrected code replaces raw whenever either correction is on
  assign sel0 = (offset_correction_enable || gain_correction_enable) ? ch0_corr : ch0_raw;
  assign sel1 = (offset_correction_enable || gain_correction_enable) ? ch1_corr : ch1_raw;
  assign upd_direct = result_valid && !gain_correction_enable;
  assign upd_late = (dly_q == 5'h01);

  // gain correction holds the result until the group delay expires
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold0_q <= afe_pkg::RESULT_RST;
      hold1_q <= afe_pkg::RESULT_RST;
    end else if (result_valid) begin
      hold0_q <= sel0;
      hold1_q <= sel1;
    end
  end

  // a restart drops any result in flight except one whose delay ends in the restart cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dly_q <= 5'h00;
    end else if (conv_restart_q) begin
      dly_q <= 5'h00;
    end else if (result_valid && gain_correction_enable) begin
      dly_q <= afe_pkg::GCAL_DELAY;
    end else if (dly_q != 5'h00) begin
      dly_q <= dly_q - 5'h01;
    end
  end

  // all bytes of both channels load in one edge; host writes never reach here
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ch0_q <= afe_pkg::RESULT_RST;
      ch1_q <= afe_pkg::RESULT_RST;
    end else if (upd_direct) begin
      ch0_q <= sel0;
      ch1_q <= sel1;
    end else if (upd_late) begin
      ch0_q <= hold0_q;
      ch1_q <= hold1_q;
    end
  end

  // data ready marks the edge where the result registers changed
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_ready_q <= 1'b0;
    end else begin
      data_ready_q <= upd_direct || upd_late;
    end
  end

  // ----------------------------------------
  // read snapshot
  // ----------------------------------------
  // first read byte freezes both channels; live registers keep updating
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      snap_v_q <= 1'b0;
      snap0_q <= afe_pkg::RESULT_RST;
      snap1_q <= afe_pkg::RESULT_RST;
    end else if (!txn_active) begin
      snap_v_q <= 1'b0;
    end else if (byte_rd && !snap_v_q) begin
      snap_v_q <= 1'b1;
      snap0_q <= ch0_q;
      snap1_q <= ch1_q;
    end
  end

  // the first byte reads live data, which is exactly what gets frozen
  always_comb begin
    src0 = snap_v_q ? snap0_q : ch0_q;
    src1 = snap_v_q ? snap1_q : ch1_q;
  end

  // ----------------------------------------
  // host byte access
  // ----------------------------------------
  // read mux; addresses outside this bank read zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q <= 8'h00;
    end else if (byte_rd) begin
      case (addr_q)
        5'h00: rd_data_q <= src0[23:16];
        5'h01: rd_data_q <= src0[15:8];
        5'h02: rd_data_q <= src0[7:0];
        5'h03: rd_data_q <= src1[23:16];
        5'h04: rd_data_q <= src1[15:8];
        5'h05: rd_data_q <= src1[7:0];
        afe_pkg::ADDR_MOD: rd_data_q <= mod_q;
        afe_pkg::ADDR_PH_HI: rd_data_q <= {4'h0, phase_q[11:8]};
        afe_pkg::ADDR_PH_LO: rd_data_q <= phase_q[7:0];
        afe_pkg::ADDR_GAIN: rd_data_q <= gain_q;
        default: rd_data_q <= 8'h00;
      endcase
    end
  end

  // address counter: reads follow the loop setting, writes walk the map
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= afe_pkg::ADDR_CH0;
    end else if (cmd_valid) begin
      addr_q <= cmd_addr;
    end else if (byte_rd) begin
      addr_q <= next_addr(addr_q, read_loop);
    end else if (byte_wr) begin
      addr_q <= next_addr(addr_q, afe_pkg::LOOP_MAP);
    end
  end

  // comparator bits stream in; a host write is taken but hurts accuracy
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mod_q <= afe_pkg::MOD_RST;
    end else if (byte_wr && addr_q == afe_pkg::ADDR_MOD) begin
      mod_q <= wr_data;
    end else if (comp_valid) begin
      mod_q <= comp_bits;
    end
  end

  // phase bytes; any write restarts the converters
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= afe_pkg::PHASE_RST;
      conv_restart_q <= 1'b0;
    end else begin
      conv_restart_q <= byte_wr && (addr_q == afe_pkg::ADDR_PH_HI || addr_q == afe_pkg::ADDR_PH_LO);
      if (byte_wr && addr_q == afe_pkg::ADDR_PH_HI) begin
        phase_q[11:8] <= wr_data[3:0];
      end
      if (byte_wr && addr_q == afe_pkg::ADDR_PH_LO) begin
        phase_q[7:0] <= wr_data;
      end
    end
  end

  // gain byte plus decoded copies so the amplifiers see a clean code
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gain_q <= afe_pkg::GAIN_RST;
      bias_sel_q <= afe_pkg::GAIN_RST[afe_pkg::BIAS_LSB +: 2];
      ch0_gain_log2_q <= 3'h0;
      ch1_gain_log2_q <= 3'h0;
    end else if (byte_wr && addr_q == afe_pkg::ADDR_GAIN) begin
      gain_q <= wr_data;
      bias_sel_q <= wr_data[afe_pkg::BIAS_LSB +: 2];
      ch1_gain_log2_q <= gain_eff(wr_data[afe_pkg::GAIN_CH1_LSB +: 3]);
      ch0_gain_log2_q <= gain_eff(wr_data[afe_pkg::GAIN_CH0_LSB +: 3]);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_result_ro: assert property (byte_wr && addr_q <= 5'h05 && !upd_direct && !upd_late |=>
    $stable(ch0_q) && $stable(ch1_q)) else $error("result changed by host write");
  a_snap_frozen: assert property (snap_v_q && txn_active |=> $stable(snap0_q) && $stable(snap1_q))
    else $error("snapshot moved during read");
  a_snap_byte: assert property (byte_rd && snap_v_q && addr_q == 5'h03 |=>
    rd_data_q == $past(snap1_q[23:16])) else $error("read not from snapshot");
  a_direct_upd: assert property (upd_direct |=> data_ready_q && ch0_q == $past(sel0))
    else $error("result not loaded");
  a_gcal_delay: assert property (result_valid && gain_correction_enable && !conv_restart_q
    ##1 (!result_valid && !conv_restart_q) [*8] ##1 (!result_valid && !conv_restart_q) [*8]
    ##1 (!result_valid && !conv_restart_q) [*8] |-> !data_ready_q ##1 data_ready_q)
    else $error("data ready not delayed by the group delay");
  a_gcal_load: assert property (upd_late && !upd_direct |=> data_ready_q && ch1_q == $past(hold1_q))
    else $error("late result lost");
  a_phase_restart: assert property (byte_wr && addr_q == afe_pkg::ADDR_PH_LO |=> conv_restart_q ##1
    !conv_restart_q || $past(byte_wr)) else $error("no restart pulse");
  a_phase_upper: assert property (byte_rd && addr_q == afe_pkg::ADDR_PH_HI |=> rd_data_q[7:4] == 4'h0)
    else $error("phase upper bits not zero");
  a_gain_resv: assert property (gain_q[2:0] > afe_pkg::GAIN_CODE_MAX |-> ch0_gain_log2_q == 3'h0)
    else $error("reserved gain not unity");
  a_gain_ch1: assert property (gain_q[5:3] <= afe_pkg::GAIN_CODE_MAX |-> ch1_gain_log2_q == gain_q[5:3])
    else $error("second channel gain wrong");
  a_mod_track: assert property (comp_valid && !(byte_wr && addr_q == afe_pkg::ADDR_MOD) |=>
    mod_q == $past(comp_bits)) else $error("comparator bits not tracked");
  a_read_loop: assert property (byte_rd && !cmd_valid && read_loop == afe_pkg::LOOP_STATIC |=>
    $stable(addr_q)) else $error("static read moved address");

  c_gcal_ready: cover property (result_valid && gain_correction_enable ##[24:25] data_ready_q);
  c_read_update: cover property (snap_v_q && txn_active && data_ready_q);
  c_phase_write: cover property (byte_wr && addr_q == afe_pkg::ADDR_PH_HI ##1 conv_restart_q);

endmodule : afe_regs

// *** dv/afe_data_phase_gain_registers_tb_top.sv ***
`timescale 1ns/1ns
module afe_data_phase_gain_registers_tb_top;
  // ----------------------------------------
  // signals and shadow state
  // ----------------------------------------
  logic clk = 1'b0, reset_n = 1'b0, result_valid = 1'b0, comp_valid = 1'b0, ofs_en = 1'b0, gn_en = 1'b0;
  logic [1:0] read_loop = afe_pkg::LOOP_TYPE;
  logic [23:0] ch0_raw = 24'h0, ch1_raw = 24'h0, ch0_corr = 24'h0, ch1_corr = 24'h0, s0, s1;
  logic [7:0] comp_bits = 8'h00, smod, sgain, rd_data_q, d;
  logic [11:0] sph, phase_q;
  logic [4:0] addr_q, cmd_addr, a;
  logic [2:0] g0, g1;
  logic [1:0] bias_sel_q;
  logic txn_active, cmd_valid, byte_rd, byte_wr, data_ready_q, conv_restart_q, rd_flag = 1'b0;
  logic [7:0] wr_data;
  logic [31:0] seed = 32'h00017835;
  logic [4:0] st [4] = '{5'h09, 5'h08, 5'h05, 5'h19};
  logic [7:0] exp_q[$];
  int miscompares = 0, checks = 0, n;

  afe_host_model i_afe_host_model (.clk(clk), .txn_active(txn_active), .cmd_valid(cmd_valid),
    .cmd_addr(cmd_addr), .byte_rd(byte_rd), .byte_wr(byte_wr), .wr_data(wr_data));
  afe_regs i_afe_regs (.clk(clk), .reset_n(reset_n), .txn_active(txn_active), .cmd_valid(cmd_valid),
    .cmd_addr(cmd_addr), .byte_rd(byte_rd), .byte_wr(byte_wr), .wr_data(wr_data), .read_loop(read_loop),
    .rd_data_q(rd_data_q), .addr_q(addr_q), .result_valid(result_valid), .ch0_raw(ch0_raw),
    .ch1_raw(ch1_raw), .ch0_corr(ch0_corr), .ch1_corr(ch1_corr), .offset_correction_enable(ofs_en),
    .gain_correction_enable(gn_en), .data_ready_q(data_ready_q), .comp_valid(comp_valid),
    .comp_bits(comp_bits), .conv_restart_q(conv_restart_q), .phase_q(phase_q), .bias_sel_q(bias_sel_q),
    .ch0_gain_log2_q(g0), .ch1_gain_log2_q(g1));

  // 25 MHz clock
  always #20 clk = ~clk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // read address step for the current loop setting
  function automatic logic [4:0] nxt(input logic [4:0] x);
    if (read_loop == afe_pkg::LOOP_STATIC) return x;
    if (read_loop == afe_pkg::LOOP_MAP) return (x == 5'h1A) ? 5'h00 : x + 5'h01;
    if (read_loop == afe_pkg::LOOP_TYPE) return (x == 5'h05) ? 5'h00 : (x == 5'h1A) ? 5'h06 : x + 5'h01;
    case (x)
      5'h02: return 5'h00;
      5'h05: return 5'h03;
      5'h09: return 5'h06;
      5'h0D: return 5'h0A;
      5'h13: return 5'h0E;
      5'h19: return 5'h14;
      5'h1A: return 5'h1A;
      default: return x + 5'h01;
    endcase
  endfunction : nxt
  function automatic logic [7:0] eb(input logic [4:0] x);
    case (x)
      5'h00: return s0[23:16];
      5'h01: return s0[15:8];
      5'h02: return s0[7:0];
      5'h03: return s1[23:16];
      5'h04: return s1[15:8];
      5'h05: return s1[7:0];
      5'h06: return smod;
      5'h07: return {4'h0, sph[11:8]};
      5'h08: return sph[7:0];
      5'h09: return sgain;
      default: return 8'h00;
    endcase
  endfunction : eb
  function automatic logic [2:0] lg(input logic [2:0] c);
    return (c > 3'h5) ? 3'h0 : c;
  endfunction : lg
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (e !== g) begin
      miscompares++;
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // note each expected read byte, then strobe it
  task automatic rdn(inout logic [4:0] x, input int k);
    for (int i = 0; i < k; i++) begin
      exp_q.push_back(eb(x));
      i_afe_host_model.xfer(1'b0, 8'h00);
      x = nxt(x);
    end
  endtask : rdn
  task automatic rd_seq(input logic [4:0] x0, input int k);
    logic [4:0] x;
    x = x0;
    i_afe_host_model.start(x);
    rdn(x, k);
    i_afe_host_model.stop();
  endtask : rd_seq
  task automatic wr1(input logic [4:0] x, input logic [7:0] v);
    i_afe_host_model.start(x);
    i_afe_host_model.xfer(1'b1, v);
    i_afe_host_model.stop();
  endtask : wr1
  // one conversion with fresh random codes, ends just after the taking edge
  task automatic res();
    @(posedge clk);
    #2;
    {ch0_raw, ch1_raw, ch0_corr, ch1_corr} = {xs(), xs(), xs()};
    result_valid = 1'b1;
    @(posedge clk);
    #2;
    result_valid = 1'b0;
  endtask : res
  task automatic complete_run();
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------
  // read data monitor and watchdog
  // ----------------------------------------
  // read byte lands on the edge that takes its strobe; the monitor checks it one edge later
  always @(posedge clk) begin
    if (rd_flag) begin
      if (exp_q.size() == 0) chk("rd_data_q note", 32'h0, 32'h1);
      else chk("rd_data_q", exp_q.pop_front(), rd_data_q);
    end
    rd_flag <= byte_rd;
  end
  // far above the few hundred cycles the sequence needs
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {s0, s1, sph, smod, sgain} = {48'h0, 12'h000, 8'h33, 8'h80};
    repeat (6) @(posedge clk);
    #2;
    reset_n = 1'b1;
    chk("phase_q", 32'h0, phase_q);
    chk("bias_sel_q", 32'h2, bias_sel_q);
    chk("gains", 32'h0, {g1, g0});
    rd_seq(afe_pkg::ADDR_MOD, 4);
    res();
    chk("data_ready_q", 32'h1, data_ready_q);
    {s0, s1} = {ch0_raw, ch1_raw};
    rd_seq(afe_pkg::ADDR_CH0, 7);
    // snapshot held while a newer conversion lands mid-read
    a = afe_pkg::ADDR_CH0;
    i_afe_host_model.start(a);
    rdn(a, 1);
    i_afe_host_model.idle();
    res();
    rdn(a, 5);
    i_afe_host_model.stop();
    {s0, s1} = {ch0_raw, ch1_raw};
    rd_seq(afe_pkg::ADDR_CH0, 6);
    // result bytes refuse writes, address still moves
    i_afe_host_model.start(afe_pkg::ADDR_CH0);
    repeat (3) i_afe_host_model.xfer(1'b1, 8'hA5);
    i_afe_host_model.stop();
    chk("addr_q", 32'h3, addr_q);
    rd_seq(afe_pkg::ADDR_CH0, 3);
    ofs_en = 1'b1;
    res();
    {s0, s1} = {ch0_corr, ch1_corr};
    rd_seq(afe_pkg::ADDR_CH0, 6);
    {ofs_en, gn_en} = 2'b01;
    res();
    for (n = 1; data_ready_q !== 1'b1 && n < 40; n++) @(posedge clk) #2;
    chk("ready delay", 32'd25, n);
    @(posedge clk) #2;
    chk("ready width", 32'h0, data_ready_q);
    {s0, s1} = {ch0_corr, ch1_corr};
    rd_seq(afe_pkg::ADDR_CH0, 3);
    gn_en = 1'b0;
    // phase bytes restart conversion
    for (int i = 0; i < 2; i++) begin
      d = xs();
      a = afe_pkg::ADDR_PH_HI + 5'(i);
      wr1(a, d);
      if (i == 0) sph[11:8] = d[3:0];
      else sph[7:0] = d;
      chk("conv_restart_q", 32'h1, conv_restart_q);
      chk("phase_q", sph, phase_q);
      chk("addr_q", a + 5'h01, addr_q);
    end
    @(posedge clk) #2;
    chk("restart width", 32'h0, conv_restart_q);
    rd_seq(afe_pkg::ADDR_PH_HI, 2);
    // every gain and bias code, reserved gains included
    for (int i = 0; i < 8; i++) begin
      d = {2'(i), 3'(7 - i), 3'(i)};
      wr1(afe_pkg::ADDR_GAIN, d);
      sgain = d;
      chk("conv_restart_q", 32'h0, conv_restart_q);
      chk("bias_sel_q", d[7:6], bias_sel_q);
      chk("ch1 gain", lg(d[5:3]), g1);
      chk("ch0 gain", lg(d[2:0]), g0);
      rd_seq(afe_pkg::ADDR_GAIN, 1);
    end
    @(posedge clk) #2;
    comp_bits = xs();
    comp_valid = 1'b1;
    @(posedge clk) #2;
    comp_valid = 1'b0;
    smod = comp_bits;
    rd_seq(afe_pkg::ADDR_MOD, 1);
    wr1(afe_pkg::ADDR_MOD, 8'h5A);
    smod = 8'h5A;
    // each read loop mode from a start near its wrap point
    for (int m = 0; m < 4; m++) begin
      read_loop = 2'(m);
      rd_seq(st[m], 4);
    end
    repeat (3) @(posedge clk);
    complete_run();
  end
endmodule : afe_data_phase_gain_registers_tb_top

// *** dv/afe_host_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// host side of the byte-level register port
// ----------------------------------------
module afe_host_model (
  // clock
  input wire logic clk,
  // register port
  output logic txn_active,
  output logic cmd_valid,
  output logic [4:0] cmd_addr,
  output logic byte_rd,
  output logic byte_wr,
  output logic [7:0] wr_data
);
  // idle lines at time zero
  initial begin
    {txn_active, cmd_valid, byte_rd, byte_wr} = 4'h0;
    cmd_addr = 5'h00;
    wr_data = 8'h00;
  end
  // open a transaction at a start address
  task automatic start(input logic [4:0] a);
    @(posedge clk);
    #2;
    txn_active = 1'b1;
    cmd_valid = 1'b1;
    cmd_addr = a;
  endtask : start
  // one byte a cycle; the modulator byte is only written when the bench asks
  task automatic xfer(input logic wr, input logic [7:0] d);
    @(posedge clk);
    #2;
    cmd_valid = 1'b0;
    cmd_addr = ~cmd_addr;
    byte_rd = ~wr;
    byte_wr = wr;
    wr_data = wr ? d : ~wr_data;
  endtask : xfer
  // pause strobes inside an open transaction
  task automatic idle();
    @(posedge clk);
    #2;
    {byte_rd, byte_wr} = 2'h0;
  endtask : idle
  // close; released lines show inverted junk so stale values cannot pass
  task automatic stop();
    @(posedge clk);
    #2;
    {txn_active, cmd_valid, byte_rd, byte_wr} = 4'h0;
    wr_data = ~wr_data;
    cmd_addr = ~cmd_addr;
  endtask : stop
endmodule : afe_host_model
